// >>> inc/glyph_defs.vh
`ifndef GLYPH_DEFS_VH
`define GLYPH_DEFS_VH

// Glyph size classes. A half-width class pairs with the full-width class of equal height.
`define SIZE_SMALL 2'h0
`define SIZE_MID 2'h1
`define SIZE_LARGE 2'h2
`define SIZE_BAD 2'h3

// Bit of a user glyph code that selects the full-width range.
`define FULL_BIT 15

// Bytes per user glyph.
`define STRIDE_H_S 8'h10
`define STRIDE_H_M 8'h30
`define STRIDE_H_L 8'h40
`define STRIDE_F_S 8'h20
`define STRIDE_F_M 8'h48
`define STRIDE_F_L 8'h80

// Glyph widths in pixels.
`define W_H_S 6'h08
`define W_H_M 6'h0C
`define W_H_L 6'h10
`define W_F_S 6'h10
`define W_F_M 6'h18
`define W_F_L 6'h20

// Glyph heights in pixels.
`define H_S 6'h10
`define H_M 6'h18
`define H_L 6'h20

// Pixels taken from one glyph byte.
`define BITS_FULL 4'h8
`define BITS_NIBBLE 4'h4

// Embedded character sets.
`define ROM_SET_LATIN1 2'h0
`define ROM_SET_LATIN2 2'h1
`define ROM_SET_LATIN4 2'h2
`define ROM_SET_CYRILLIC 2'h3

// Embedded store address layout: {size, set, code, byte}.
`define ROM_CODE_W 8
`define ROM_BYTE_W 6
`define ROM_ADDR_W 18
`define PROD_W 24

`endif

// >>> core/glyph_addr_calc.v
`include "glyph_defs.vh"

module glyph_addr_calc #(
  parameter ADDR_W = 32
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire start_in,
  input wire [15:0] code_in,
  input wire [1:0] size_in,
  input wire [ADDR_W-1:0] base_in,
  output reg [ADDR_W-1:0] addr_out
);

  function [7:0] stride;
    input [1:0] size;
    input full;
    begin
      case (size)
        `SIZE_SMALL: stride = full ? `STRIDE_F_S : `STRIDE_H_S;
        `SIZE_MID: stride = full ? `STRIDE_F_M : `STRIDE_H_M;
        `SIZE_LARGE: stride = full ? `STRIDE_F_L : `STRIDE_H_L;
        default: stride = 8'h00;
      endcase
    end
  endfunction

  wire [`PROD_W-1:0] prod;
  wire [ADDR_W-1:0] nxt_addr;

  // The code is a relative glyph index; base plus code times stride is absolute.
  assign prod = code_in * stride(size_in, code_in[`FULL_BIT]);
  assign nxt_addr = base_in + {{(ADDR_W-`PROD_W){1'b0}}, prod};

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_out <= {ADDR_W{1'b0}};
    end else if (start_in) begin
      addr_out <= nxt_addr;
    end
  end

endmodule

// >>> core/text_glyph_render.v
// Operation
// - Glyphs come from embedded store or user area.
// - Embedded store offers four 8-bit character sets.
// - Embedded glyphs in 8x16, 12x24, 16x32.
// - Latin-1 codes 80h-9Fh are printable glyphs.
// - User codes below 8000h are half width.
// - User codes 8000h and above are full width.
// - Full width sizes 16x16, 24x24, 32x32.
// - Code becomes absolute address, glyph copied out.
// - Set pixels foreground, clear pixels background.
// - 8x16 glyph address is base plus code*16.
// - 16x16 glyph address is base plus code*32.
// - 12x24 glyph address is base plus code*48.
// - 12x24 odd bytes drop their low nibble.
// - 24x24 glyph address is base plus code*72.
// - 16x32 glyph address is base plus code*64.
// - 32x32 glyph address is base plus code*128.
// - Glyph bytes fetched at ascending consecutive addresses.
`include "glyph_defs.vh"

module text_glyph_render #(
  parameter ADDR_W = 32,
  parameter COLOR_W = 24
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire char_valid_in,
  output wire char_ready_out,
  input wire [15:0] char_code_in,
  input wire user_glyph_sel_in,
  input wire [1:0] rom_set_in,
  input wire [1:0] glyph_size_in,
  input wire [ADDR_W-1:0] glyph_area_base_in,
  input wire [COLOR_W-1:0] fg_color_in,
  input wire [COLOR_W-1:0] bg_color_in,
  input wire [ADDR_W-1:0] dest_addr_in,
  input wire [ADDR_W-1:0] line_pitch_in,
  output wire rom_rd_out,
  output wire [`ROM_ADDR_W-1:0] rom_addr_out,
  input wire [7:0] rom_data_in,
  output wire mem_rd_req_out,
  output wire [ADDR_W-1:0] mem_rd_addr_out,
  input wire mem_rd_ack_in,
  input wire [7:0] mem_rd_data_in,
  output wire pix_valid_out,
  input wire pix_ready_in,
  output wire [ADDR_W-1:0] pix_addr_out,
  output wire [COLOR_W-1:0] pix_color_out,
  output wire busy_out,
  output reg done_out,
  output reg size_err_out
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_FETCH = 3'h2;
  localparam ST_ROMWAIT = 3'h3;
  localparam ST_DRAW = 3'h4;

  function [5:0] glyph_width;
    input [1:0] size;
    input full;
    begin
      case (size)
        `SIZE_SMALL: glyph_width = full ? `W_F_S : `W_H_S;
        `SIZE_MID: glyph_width = full ? `W_F_M : `W_H_M;
        `SIZE_LARGE: glyph_width = full ? `W_F_L : `W_H_L;
        default: glyph_width = `W_H_S;
      endcase
    end
  endfunction

  function [5:0] glyph_height;
    input [1:0] size;
    begin
      case (size)
        `SIZE_SMALL: glyph_height = `H_S;
        `SIZE_MID: glyph_height = `H_M;
        `SIZE_LARGE: glyph_height = `H_L;
        default: glyph_height = `H_S;
      endcase
    end
  endfunction

  // Pixels contributed by a byte; only the 12-wide half size uses a nibble.
  function [3:0] byte_bits;
    input [1:0] size;
    input full;
    input odd;
    begin
      if (size == `SIZE_MID && !full && odd) begin
        byte_bits = `BITS_NIBBLE;
      end else begin
        byte_bits = `BITS_FULL;
      end
    end
  endfunction

  reg [2:0] state_ff;
  reg [15:0] code_ff;
  reg user_ff;
  reg full_ff;
  reg [1:0] set_ff;
  reg [1:0] size_ff;
  reg [COLOR_W-1:0] fg_ff;
  reg [COLOR_W-1:0] bg_ff;
  reg [ADDR_W-1:0] pitch_ff;
  reg [ADDR_W-1:0] row_base_ff;
  reg [ADDR_W-1:0] pix_addr_ff;
  reg [COLOR_W-1:0] pix_color_ff;
  reg [ADDR_W-1:0] mem_addr_ff;
  reg [6:0] byte_idx_ff;
  reg [5:0] x_ff;
  reg [5:0] y_ff;
  reg [5:0] w_ff;
  reg [5:0] h_ff;
  reg [7:0] shift_ff;
  reg [3:0] bits_left_ff;

  wire [ADDR_W-1:0] glyph_start;
  wire accept;
  wire byte_in;
  wire [7:0] byte_data;
  wire advance;
  wire last_bit;
  wire row_end;
  wire last_row;
  wire [ADDR_W-1:0] next_row_base;
  wire [7:0] shifted;
  wire in_full;

  glyph_addr_calc #(
    .ADDR_W(ADDR_W)
  ) u_addr (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .start_in(accept),
    .code_in(char_code_in),
    .size_in(glyph_size_in),
    .base_in(glyph_area_base_in),
    .addr_out(glyph_start)
  );

  assign char_ready_out = (state_ff == ST_IDLE);
  assign accept = char_valid_in && char_ready_out;
  assign busy_out = (state_ff != ST_IDLE);

  // Only user glyph codes reach the full-width range; embedded codes are 8-bit.
  assign in_full = user_glyph_sel_in && char_code_in[`FULL_BIT];

  // Embedded store address; every code of a set, 80h-9Fh included, has a glyph.
  assign rom_rd_out = (state_ff == ST_FETCH) && !user_ff;
  assign rom_addr_out = {size_ff, set_ff, code_ff[`ROM_CODE_W-1:0],
                         byte_idx_ff[`ROM_BYTE_W-1:0]};

  assign mem_rd_req_out = (state_ff == ST_FETCH) && user_ff;
  assign mem_rd_addr_out = mem_addr_ff;

  assign byte_in = (state_ff == ST_FETCH && user_ff && mem_rd_ack_in) ||
                   (state_ff == ST_ROMWAIT);
  assign byte_data = user_ff ? mem_rd_data_in : rom_data_in;

  assign pix_valid_out = (state_ff == ST_DRAW);
  assign pix_addr_out = pix_addr_ff;
  assign pix_color_out = pix_color_ff;

  assign advance = (state_ff == ST_DRAW) && pix_ready_in;
  assign last_bit = (bits_left_ff == 4'h1);
  assign row_end = (x_ff == w_ff - 6'h01);
  assign last_row = (y_ff == h_ff - 6'h01);
  assign next_row_base = row_base_ff + pitch_ff;
  assign shifted = {shift_ff[6:0], 1'b0};

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
      code_ff <= 16'h0000;
      user_ff <= 1'b0;
      full_ff <= 1'b0;
      set_ff <= `ROM_SET_LATIN1;
      size_ff <= `SIZE_SMALL;
      fg_ff <= {COLOR_W{1'b0}};
      bg_ff <= {COLOR_W{1'b0}};
      pitch_ff <= {ADDR_W{1'b0}};
      row_base_ff <= {ADDR_W{1'b0}};
      w_ff <= `W_H_S;
      h_ff <= `H_S;
      size_err_out <= 1'b0;
    end else begin
      size_err_out <= 1'b0;
      if (accept) begin
        if (glyph_size_in == `SIZE_BAD) begin
          // An unsupported size is consumed and flagged, nothing is drawn.
          size_err_out <= 1'b1;
        end else begin
          code_ff <= char_code_in;
          user_ff <= user_glyph_sel_in;
          full_ff <= in_full;
          set_ff <= rom_set_in;
          size_ff <= glyph_size_in;
          // Colors are held for the whole glyph so a host update cannot tear it.
          fg_ff <= fg_color_in;
          bg_ff <= bg_color_in;
          pitch_ff <= line_pitch_in;
          row_base_ff <= dest_addr_in;
          w_ff <= glyph_width(glyph_size_in, in_full);
          h_ff <= glyph_height(glyph_size_in);
          // The start address is latched on accept so it is settled during the address state.
          state_ff <= ST_ADDR;
        end
      end else begin
        case (state_ff)
          ST_IDLE: begin
            state_ff <= ST_IDLE;
          end
          ST_ADDR: begin
            state_ff <= ST_FETCH;
          end
          ST_FETCH: begin
            if (!user_ff) begin
              state_ff <= ST_ROMWAIT;
            end else if (mem_rd_ack_in) begin
              state_ff <= ST_DRAW;
            end
          end
          ST_ROMWAIT: begin
            state_ff <= ST_DRAW;
          end
          ST_DRAW: begin
            if (advance && last_bit) begin
              if (row_end) begin
                row_base_ff <= next_row_base;
                state_ff <= last_row ? ST_IDLE : ST_FETCH;
              end else begin
                state_ff <= ST_FETCH;
              end
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Byte walk and pixel generation.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_addr_ff <= {ADDR_W{1'b0}};
      byte_idx_ff <= 7'h00;
      x_ff <= 6'h00;
      y_ff <= 6'h00;
      shift_ff <= 8'h00;
      bits_left_ff <= 4'h0;
      pix_addr_ff <= {ADDR_W{1'b0}};
      pix_color_ff <= {COLOR_W{1'b0}};
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (accept) begin
        byte_idx_ff <= 7'h00;
        x_ff <= 6'h00;
        y_ff <= 6'h00;
        pix_addr_ff <= dest_addr_in;
      end
      if (state_ff == ST_ADDR) begin
        mem_addr_ff <= glyph_start;
      end
      if (byte_in) begin
        shift_ff <= byte_data;
        bits_left_ff <= byte_bits(size_ff, full_ff, byte_idx_ff[0]);
        pix_color_ff <= byte_data[7] ? fg_ff : bg_ff;
      end
      if (advance) begin
        if (last_bit) begin
          byte_idx_ff <= byte_idx_ff + 7'h01;
          mem_addr_ff <= mem_addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
          if (row_end) begin
            x_ff <= 6'h00;
            y_ff <= y_ff + 6'h01;
            pix_addr_ff <= next_row_base;
            done_out <= last_row;
          end else begin
            x_ff <= x_ff + 6'h01;
            pix_addr_ff <= pix_addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
          end
        end else begin
          shift_ff <= shifted;
          bits_left_ff <= bits_left_ff - 4'h1;
          pix_color_ff <= shifted[7] ? fg_ff : bg_ff;
          x_ff <= x_ff + 6'h01;
          pix_addr_ff <= pix_addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// >>> bench/glyph_mem_model.sv
module glyph_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  output logic ack_out,
  output logic [7:0] data_out,
  input wire logic rom_rd_in,
  input wire logic [17:0] rom_addr_in,
  output logic [7:0] rom_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] dly_ff;
  logic [1:0] cnt_ff;

  // Glyph contents are a fixed function of the byte address, computed at each read.
  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction

  // Data lines show inverted garbage whenever no answer is due.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      data_out <= 8'h00;
      rom_data_out <= 8'h00;
      dly_ff <= 2'h0;
      cnt_ff <= 2'h0;
    end else begin
      rom_data_out <= rom_rd_in ? pat(32'(rom_addr_in)) : ~rom_data_out;
      if (ack_out) begin
        ack_out <= 1'b0;
        data_out <= ~data_out;
        dly_ff <= (dly_ff == 2'h2) ? 2'h0 : dly_ff + 2'h1;
        cnt_ff <= dly_ff;
      end else if (req_in && cnt_ff == 2'h0) begin
        ack_out <= 1'b1;
        data_out <= pat(addr_in);
      end else begin
        cnt_ff <= cnt_ff - {1'b0, cnt_ff != 2'h0};
        data_out <= ~data_out;
      end
    end
  end
endmodule

// >>> bench/text_glyph_render_properties.sv
module text_glyph_render_properties #(
  parameter ADDR_W = 32,
  parameter COLOR_W = 24
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire char_valid_in,
  input wire char_ready_out,
  input wire [1:0] glyph_size_in,
  input wire busy_out,
  input wire done_out,
  input wire size_err_out,
  input wire mem_rd_req_out,
  input wire mem_rd_ack_in,
  input wire [ADDR_W-1:0] mem_rd_addr_out,
  input wire rom_rd_out,
  input wire pix_valid_out,
  input wire pix_ready_in,
  input wire [ADDR_W-1:0] pix_addr_out,
  input wire [COLOR_W-1:0] pix_color_out,
  input wire [COLOR_W-1:0] fg_color_in,
  input wire [COLOR_W-1:0] bg_color_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_ready_idle: assert property (char_ready_out == !busy_out)
    else $error("ready does not mirror idle");
  a_size_err: assert property (char_valid_in && char_ready_out && glyph_size_in == 2'h3
    |=> size_err_out && char_ready_out) else $error("bad size not flagged");
  a_accept_busy: assert property (char_valid_in && char_ready_out && glyph_size_in != 2'h3
    |=> busy_out && !size_err_out) else $error("accepted char did not start");
  a_req_hold: assert property (mem_rd_req_out && !mem_rd_ack_in
    |=> mem_rd_req_out && $stable(mem_rd_addr_out)) else $error("read request dropped");
  a_pix_hold: assert property (pix_valid_out && !pix_ready_in
    |=> pix_valid_out && $stable(pix_addr_out) && $stable(pix_color_out))
    else $error("pixel changed while stalled");
  a_pix_color: assert property (pix_valid_out |->
    pix_color_out == fg_color_in || pix_color_out == bg_color_in) else $error("pixel color");
  a_no_overlap: assert property (pix_valid_out |-> !mem_rd_req_out && !rom_rd_out)
    else $error("fetch during draw");
  a_rom_seq: assert property (rom_rd_out |=> !rom_rd_out && !pix_valid_out ##1 pix_valid_out)
    else $error("embedded fetch timing");
  a_done_pulse: assert property (done_out |-> char_ready_out ##1 !done_out)
    else $error("done not a one cycle pulse");
endmodule

bind text_glyph_render text_glyph_render_properties #(.ADDR_W(ADDR_W), .COLOR_W(COLOR_W))
  u_props (.*);

// >>> bench/tb_text_glyph_render.sv
module tb_text_glyph_render;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, rst_in = 1, char_valid_in = 0, user_glyph_sel_in = 0;
  logic pix_ready_in = 0, mem_rd_ack_in, rom_rd_out, mem_rd_req_out, pix_valid_out;
  logic char_ready_out, busy_out, done_out, size_err_out;
  logic [15:0] char_code_in = 0;
  logic [1:0] rom_set_in = 0, glyph_size_in = 0;
  logic [31:0] glyph_area_base_in = 32'h0000_1000, dest_addr_in = 32'h0002_0000;
  logic [31:0] line_pitch_in = 32'h0000_0400, mem_rd_addr_out, pix_addr_out;
  logic [23:0] fg_color_in = 24'hF00F33, bg_color_in = 24'h0CA055, pix_color_out;
  logic [17:0] rom_addr_out;
  logic [7:0] rom_data_in, mem_rd_data_in;
  int fails = 0, num_checks = 0, cyc = 0, k = 0;

  text_glyph_render dut (.*);
  glyph_mem_model mem (.clk_in(core_clk_in), .rst_in(rst_in), .req_in(mem_rd_req_out),
    .addr_in(mem_rd_addr_out), .ack_out(mem_rd_ack_in), .data_out(mem_rd_data_in),
    .rom_rd_in(rom_rd_out), .rom_addr_in(rom_addr_out), .rom_data_out(rom_data_in));

  always #10 core_clk_in = ~core_clk_in;

  task give_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      give_verdict;
    end
  end

  task chk(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task send(logic u, logic [1:0] set, logic [1:0] sz, logic [15:0] code);
    @(posedge core_clk_in);
    char_valid_in <= 1'b1;
    user_glyph_sel_in <= u;
    rom_set_in <= set;
    glyph_size_in <= sz;
    char_code_in <= code;
    do @(negedge core_clk_in); while (char_ready_out !== 1'b1);
    @(posedge core_clk_in);
    char_valid_in <= 1'b0;
  endtask

  // Draws one glyph with a stalling sink and checks every pixel against the stored bytes.
  task draw(logic u, logic [1:0] set, logic [1:0] sz, logic [15:0] code);
    int w, h, bpr, n, row, x, idx;
    logic [31:0] a;
    logic [7:0] d;
    h = 16 + 8 * sz;
    w = (u && code[15]) ? h : 8 + 4 * sz;
    bpr = (w + 7) / 8;
    n = 0;
    send(u, set, sz, code);
    while (n < w * h) begin
      @(negedge core_clk_in);
      if (pix_valid_out === 1'b1 && pix_ready_in === 1'b1) begin
        row = n / w;
        x = n % w;
        idx = row * bpr + x / 8;
        a = u ? glyph_area_base_in + code * bpr * h + idx : 32'({sz, set, code[7:0], idx[5:0]});
        d = mem.pat(a);
        chk("pix_addr", dest_addr_in + row * line_pitch_in + x, pix_addr_out);
        chk("pix_color", d[7 - x % 8] ? fg_color_in : bg_color_in, pix_color_out);
        n++;
      end
      @(posedge core_clk_in);
      k++;
      pix_ready_in <= (k % 3 != 0);
    end
    @(negedge core_clk_in);
    chk("done_out", 1, done_out);
  endtask

  task test_rom_sets;
    for (int s = 0; s < 4; s++) begin
      draw(0, s[1:0], s % 3, s == 0 ? 16'h0085 : 16'h0041 + s);
    end
  endtask

  task test_user_sizes;
    for (int s = 0; s < 3; s++) begin
      draw(1, 0, s[1:0], 16'h7FFF);
      draw(1, 0, s[1:0], s == 2 ? 16'hFFFF : 16'h8000 + s);
    end
  endtask

  task test_size_err;
    send(1, 0, 2'h3, 16'h0001);
    @(negedge core_clk_in);
    chk("size_err_out", 1, size_err_out);
    chk("busy_out", 0, busy_out);
    draw(1, 0, 0, 16'h0000);
  endtask

  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    test_rom_sets;
    test_user_sizes;
    test_size_err;
    give_verdict;
  end
endmodule
